// *** common/bbc_defs.svh ***
// bbc_defs.svh: offsets, field positions, reset values and clock counts
// assumes inclusion by bare name from the package and the core module
`ifndef BBC_DEFS_SVH
`define BBC_DEFS_SVH

// register port offsets (word index on the 4-bit address)
`define BBC_REG_PSW 4'h0
`define BBC_REG_STAT 4'h1
`define BBC_REG_LAST_CYC 4'h2

// program status word fields
`define BBC_PSW_CY 0
`define BBC_PSW_RBS0 3
`define BBC_PSW_AC 4
`define BBC_PSW_RBS1 5
`define BBC_PSW_Z 6
`define BBC_PSW_IE 7
`define BBC_PSW_RESET 8'h02

// status register fields
`define BBC_STAT_WAKE 0
`define BBC_STAT_BUSY 7

// encoded lengths in bytes
`define BBC_LEN_1 3'h1
`define BBC_LEN_2 3'h2
`define BBC_LEN_3 3'h3
`define BBC_LEN_4 3'h4

// instruction clocks; _F fast area or no data access, _S any other area
`define BBC_CYC_BT_SADDR_F 5'h08
`define BBC_CYC_BT_SADDR_S 5'h09
`define BBC_CYC_BT_SFR 5'h0b
`define BBC_CYC_BT_ACC 5'h08
`define BBC_CYC_BT_PSW 5'h09
`define BBC_CYC_BF_SADDR_F 5'h0a
`define BBC_CYC_BF_SADDR_S 5'h0b
`define BBC_CYC_BF_SFR 5'h0b
`define BBC_CYC_BF_PSW 5'h0b
`define BBC_CYC_PTR_F 5'h0a
`define BBC_CYC_PTR_S 5'h0b
`define BBC_CYC_BC_SADDR_F 5'h0a
`define BBC_CYC_BC_SADDR_S 5'h0c
`define BBC_CYC_BC_SFR 5'h0c
`define BBC_CYC_BC_PSW 5'h0c
`define BBC_CYC_BC_PTR_S 5'h0c
`define BBC_CYC_ACC_BIT 5'h08
`define BBC_CYC_DEC_REG 5'h06
`define BBC_CYC_DEC_SADDR_F 5'h08
`define BBC_CYC_DEC_SADDR_S 5'h0a
`define BBC_CYC_SEL 5'h04
`define BBC_CYC_NOP 5'h02
`define BBC_CYC_CTRL 5'h06

`endif

// *** common/bbc_pkg.sv ***
// bbc_pkg: types shared by the execution core and its surroundings
// assumes bbc_defs.svh is on the include path
package bbc_pkg;
  `include "bbc_defs.svh"

  typedef enum logic [3:0] {
    BBC_OP_NOP,
    BBC_OP_BRANCH_IF_BIT_SET,
    BBC_OP_BRANCH_IF_BIT_CLEAR,
    BBC_OP_BRANCH_AND_CLEAR_BIT,
    BBC_OP_DECREMENT_BRANCH_NONZERO,
    BBC_OP_SELECT_BANK,
    BBC_OP_ENABLE_INTERRUPT,
    BBC_OP_DISABLE_INTERRUPT,
    BBC_OP_HALT,
    BBC_OP_STOP
  } bbc_op_t;

  typedef enum logic [2:0] {
    BBC_MODE_NONE,
    BBC_MODE_SADDR,
    BBC_MODE_SFR,
    BBC_MODE_ACC,
    BBC_MODE_PSW,
    BBC_MODE_POINTER,
    BBC_MODE_REG_B,
    BBC_MODE_REG_C
  } bbc_mode_t;

  typedef enum logic [1:0] {
    BBC_RUN,
    BBC_HALT,
    BBC_STOP
  } bbc_standby_t;

  typedef struct packed {
    bbc_op_t op;
    bbc_mode_t mode;
    logic [2:0] bit_sel;
    logic [7:0] disp;
    logic [15:0] pc;
    logic [7:0] operand;
    logic hs_ram;
    logic ext_prog;
  } bbc_req_t;

  typedef struct packed {
    logic [15:0] next_pc;
    logic taken;
    logic wr_en;
    bbc_mode_t wr_mode;
    logic [7:0] wr_data;
    logic illegal;
  } bbc_res_t;
endpackage

// *** core/bbc_exec.sv ***
// bbc_exec: bit branch, loop and cpu control instruction execution
// assumes a decoder presents one decoded instruction with its operand byte,
// and that the caller performs the operand write-back it is handed
//
// Operation
// - one instruction clock is one period of i_clk, the cpu clock
// - fast count for high-speed ram or no data access, else slow
// - set-branch on saddr bit: 3 bytes, 8 or 9 clocks
// - set-branch on sfr bit: 4 bytes, 11 clocks
// - set-branch on acc bit 3 bytes 8 clocks, status bit 9 clocks
// - set-branch on pointer memory bit: 3 bytes, 10 or 11 clocks
// - clear-branch on saddr bit: 4 bytes, 10 or 11 clocks
// - clear-branch on sfr or status bit: 4 bytes, 11 clocks
// - clear-branch acc bit 3 bytes 8 clocks, pointer 10 or 11
// - branch-and-clear saddr bit: 4 bytes, 10 or 12, clears bit
// - branch-and-clear sfr bit: 4 bytes, 12 clocks, clears bit
// - branch-and-clear acc 3 bytes 8, pointer 3 bytes 10 or 12
// - branch-and-clear status bit: 4 bytes, 12, flags may change
// - decrement-branch on b or c: 2 bytes, 6 clocks
// - decrement-branch on saddr byte: 3 bytes, 8 or 10 clocks
// - bank select: 2 bytes, 4 clocks, writes the two bank bits
// - enable interrupt: 2 bytes, 6 clocks, sets the enable flag
// - disable interrupt: 2 bytes, 6 clocks, clears the enable flag
// - counts hold from internal rom; external fetch adds wait clocks
`timescale 1ns/1ps
`include "bbc_defs.svh"
module bbc_exec #(
  parameter int P_EXT_WAIT = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // instruction request
  input wire logic i_req_valid,
  input wire bbc_pkg::bbc_req_t i_req,
  output logic o_req_ready,
  // instruction result
  output logic o_done,
  output bbc_pkg::bbc_res_t o_res,
  // cpu state
  output logic [7:0] o_psw,
  output bbc_pkg::bbc_standby_t o_standby,
  // wake from standby, asynchronous pin
  input wire logic i_wake,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata
);
  import bbc_pkg::*;

  if (P_EXT_WAIT < 0 || P_EXT_WAIT > 16) begin : g_chk
    $error("P_EXT_WAIT must lie in 0..16");
  end

  localparam logic [4:0] LP_EXT_WAIT = 5'(P_EXT_WAIT);

  logic [5:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  bbc_res_t res_reg, res_next;
  logic [7:0] psw_reg, psw_next;
  logic [7:0] psw_pend_reg, psw_pend_next;
  logic [7:0] psw_mask_reg, psw_mask_next;
  bbc_standby_t standby_reg, standby_next;
  bbc_standby_t sb_pend_reg, sb_pend_next;
  logic [5:0] last_cyc_reg, last_cyc_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wake_s1_reg, wake_s2_reg, wake_d_reg;

  // decode scratch
  logic [2:0] len;
  logic [4:0] cyc;
  logic [7:0] src;
  logic [7:0] mask;
  logic bit_val;
  logic cond;
  logic clr_bit;
  logic [7:0] dec_val;
  logic [15:0] seq_pc;
  logic [15:0] tgt_pc;
  logic accept;
  logic commit;
  logic wake_evt;
  logic sw_wake;
  logic busy;

  assign accept = i_req_valid && o_req_ready;
  assign commit = (cnt_reg == 6'h01);
  assign busy = (cnt_reg != 6'h00);

  // length, clocks and outcome of the offered instruction
  always_comb begin
    len = `BBC_LEN_2;
    cyc = `BBC_CYC_NOP;
    cond = 1'b0;
    clr_bit = 1'b0;
    src = (i_req.mode == BBC_MODE_PSW) ? psw_reg : i_req.operand;
    mask = 8'h01 << i_req.bit_sel;
    bit_val = |(src & mask);
    dec_val = i_req.operand - 8'h01;
    res_next = res_reg;
    res_next.illegal = 1'b0;
    res_next.wr_en = 1'b0;
    res_next.wr_mode = i_req.mode;
    res_next.wr_data = i_req.operand;
    psw_pend_next = psw_reg;
    psw_mask_next = 8'h00;
    sb_pend_next = BBC_RUN;
    case (i_req.op)
      BBC_OP_BRANCH_IF_BIT_SET: begin
        cond = bit_val;
        case (i_req.mode)
          BBC_MODE_SADDR: begin
            len = `BBC_LEN_3;
            cyc = i_req.hs_ram ? `BBC_CYC_BT_SADDR_F : `BBC_CYC_BT_SADDR_S;
          end
          BBC_MODE_SFR: begin
            len = `BBC_LEN_4;
            cyc = `BBC_CYC_BT_SFR;
          end
          BBC_MODE_ACC: begin
            len = `BBC_LEN_3;
            cyc = `BBC_CYC_ACC_BIT;
          end
          BBC_MODE_PSW: begin
            len = `BBC_LEN_3;
            cyc = `BBC_CYC_BT_PSW;
          end
          BBC_MODE_POINTER: begin
            len = `BBC_LEN_3;
            cyc = i_req.hs_ram ? `BBC_CYC_PTR_F : `BBC_CYC_PTR_S;
          end
          default: res_next.illegal = 1'b1;
        endcase
      end
      BBC_OP_BRANCH_IF_BIT_CLEAR: begin
        cond = !bit_val;
        case (i_req.mode)
          BBC_MODE_SADDR: begin
            len = `BBC_LEN_4;
            cyc = i_req.hs_ram ? `BBC_CYC_BF_SADDR_F : `BBC_CYC_BF_SADDR_S;
          end
          BBC_MODE_SFR: begin
            len = `BBC_LEN_4;
            cyc = `BBC_CYC_BF_SFR;
          end
          BBC_MODE_PSW: begin
            len = `BBC_LEN_4;
            cyc = `BBC_CYC_BF_PSW;
          end
          BBC_MODE_ACC: begin
            len = `BBC_LEN_3;
            cyc = `BBC_CYC_ACC_BIT;
          end
          BBC_MODE_POINTER: begin
            len = `BBC_LEN_3;
            cyc = i_req.hs_ram ? `BBC_CYC_PTR_F : `BBC_CYC_PTR_S;
          end
          default: res_next.illegal = 1'b1;
        endcase
      end
      BBC_OP_BRANCH_AND_CLEAR_BIT: begin
        cond = bit_val;
        clr_bit = bit_val;
        case (i_req.mode)
          BBC_MODE_SADDR: begin
            len = `BBC_LEN_4;
            cyc = i_req.hs_ram ? `BBC_CYC_BC_SADDR_F : `BBC_CYC_BC_SADDR_S;
          end
          BBC_MODE_SFR: begin
            len = `BBC_LEN_4;
            cyc = `BBC_CYC_BC_SFR;
          end
          BBC_MODE_ACC: begin
            len = `BBC_LEN_3;
            cyc = `BBC_CYC_ACC_BIT;
          end
          BBC_MODE_POINTER: begin
            len = `BBC_LEN_3;
            cyc = i_req.hs_ram ? `BBC_CYC_PTR_F : `BBC_CYC_BC_PTR_S;
          end
          BBC_MODE_PSW: begin
            len = `BBC_LEN_4;
            cyc = `BBC_CYC_BC_PSW;
          end
          default: begin
            res_next.illegal = 1'b1;
            clr_bit = 1'b0;
          end
        endcase
        // cleared bit goes back to its owner; status bits stay inside
        if (clr_bit && i_req.mode == BBC_MODE_PSW) begin
          psw_pend_next = psw_reg & ~mask;
          psw_mask_next = mask;
        end else if (clr_bit) begin
          res_next.wr_en = 1'b1;
          res_next.wr_data = src & ~mask;
        end
      end
      BBC_OP_DECREMENT_BRANCH_NONZERO: begin
        cond = (dec_val != 8'h00);
        res_next.wr_data = dec_val;
        case (i_req.mode)
          BBC_MODE_REG_B, BBC_MODE_REG_C: begin
            len = `BBC_LEN_2;
            cyc = `BBC_CYC_DEC_REG;
            res_next.wr_en = 1'b1;
          end
          BBC_MODE_SADDR: begin
            len = `BBC_LEN_3;
            cyc = i_req.hs_ram ? `BBC_CYC_DEC_SADDR_F : `BBC_CYC_DEC_SADDR_S;
            res_next.wr_en = 1'b1;
          end
          default: begin
            res_next.illegal = 1'b1;
            cond = 1'b0;
          end
        endcase
      end
      BBC_OP_SELECT_BANK: begin
        cyc = `BBC_CYC_SEL;
        psw_pend_next[`BBC_PSW_RBS1] = i_req.bit_sel[1];
        psw_pend_next[`BBC_PSW_RBS0] = i_req.bit_sel[0];
        psw_mask_next[`BBC_PSW_RBS1] = 1'b1;
        psw_mask_next[`BBC_PSW_RBS0] = 1'b1;
      end
      BBC_OP_ENABLE_INTERRUPT: begin
        cyc = `BBC_CYC_CTRL;
        psw_pend_next[`BBC_PSW_IE] = 1'b1;
        psw_mask_next[`BBC_PSW_IE] = 1'b1;
      end
      BBC_OP_DISABLE_INTERRUPT: begin
        cyc = `BBC_CYC_CTRL;
        psw_pend_next[`BBC_PSW_IE] = 1'b0;
        psw_mask_next[`BBC_PSW_IE] = 1'b1;
      end
      BBC_OP_HALT: begin
        cyc = `BBC_CYC_CTRL;
        sb_pend_next = BBC_HALT;
      end
      BBC_OP_STOP: begin
        cyc = `BBC_CYC_CTRL;
        sb_pend_next = BBC_STOP;
      end
      BBC_OP_NOP: begin
        len = `BBC_LEN_1;
        cyc = `BBC_CYC_NOP;
      end
      default: res_next.illegal = 1'b1;
    endcase
    if (res_next.illegal) begin
      cond = 1'b0;
      len = `BBC_LEN_1;
      cyc = `BBC_CYC_NOP;
    end
    seq_pc = i_req.pc + {13'h0000, len};
    tgt_pc = seq_pc + {{8{i_req.disp[7]}}, i_req.disp};
    res_next.taken = cond;
    res_next.next_pc = cond ? tgt_pc : seq_pc;
    // hold the captured instruction between takes
    if (!accept) begin
      res_next = res_reg;
      psw_pend_next = psw_pend_reg;
      psw_mask_next = psw_mask_reg;
      sb_pend_next = sb_pend_reg;
    end
  end

  // wake event: pin edge after two flops, or software write
  assign wake_evt = wake_s2_reg && !wake_d_reg;
  assign sw_wake = i_reg_wr && (i_reg_addr == `BBC_REG_STAT) && i_reg_wdata[`BBC_STAT_WAKE];

  // sequencing, status word and standby
  always_comb begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    psw_next = psw_reg;
    standby_next = standby_reg;
    last_cyc_next = last_cyc_reg;
    if (i_reg_wr && i_reg_addr == `BBC_REG_PSW) begin
      psw_next = i_reg_wdata;
    end
    if ((wake_evt || sw_wake) && standby_reg != BBC_RUN) begin
      standby_next = BBC_RUN;
    end
    if (accept) begin
      // one count per i_clk period, plus external fetch waits
      cnt_next = {1'b0, cyc} + (i_req.ext_prog ? {1'b0, LP_EXT_WAIT} : 6'h00) - 6'h01;
      last_cyc_next = cnt_next + 6'h01;
    end else if (busy) begin
      cnt_next = cnt_reg - 6'h01;
    end
    // instruction effects land on its last clock and win over software
    if (commit) begin
      done_next = 1'b1;
      psw_next = (psw_next & ~psw_mask_reg) | (psw_pend_reg & psw_mask_reg);
      standby_next = sb_pend_reg;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `BBC_REG_PSW: rdata_next = psw_reg;
        `BBC_REG_STAT: rdata_next = {busy, 5'h00, standby_reg};
        `BBC_REG_LAST_CYC: rdata_next = {2'h0, last_cyc_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // sequencing and cpu state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 6'h00;
      done_reg <= 1'b0;
      psw_reg <= `BBC_PSW_RESET;
      standby_reg <= BBC_RUN;
      last_cyc_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      psw_reg <= psw_next;
      standby_reg <= standby_next;
      last_cyc_reg <= last_cyc_next;
    end
  end

  // result and pending effects of the taken instruction
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      res_reg <= '0;
      psw_pend_reg <= `BBC_PSW_RESET;
      psw_mask_reg <= 8'h00;
      sb_pend_reg <= BBC_RUN;
    end else begin
      res_reg <= res_next;
      psw_pend_reg <= psw_pend_next;
      psw_mask_reg <= psw_mask_next;
      sb_pend_reg <= sb_pend_next;
    end
  end

  // register port read data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // wake pin synchroniser and edge history
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_d_reg <= 1'b0;
    end else begin
      wake_s1_reg <= i_wake;
      wake_s2_reg <= wake_s1_reg;
      wake_d_reg <= wake_s2_reg;
    end
  end

  assign o_req_ready = !busy && (standby_reg == BBC_RUN);
  assign o_done = done_reg;
  assign o_res = res_reg;
  assign o_psw = psw_reg;
  assign o_standby = standby_reg;
  assign o_reg_rdata = rdata_reg;
endmodule

// *** tb/bbc_mem_model.sv ***
// bbc_mem_model: data memory bytes seen by the execution core
// assumes i_idx stays steady until the write-back edge
`timescale 1ns/1ps
module bbc_mem_model (
  // clock
  input wire logic i_clk,
  // byte select and result
  input wire logic [3:0] i_idx,
  input wire logic i_done,
  input wire bbc_pkg::bbc_res_t i_res,
  output logic [7:0] o_byte
);
  import bbc_pkg::*;
  logic [7:0] mem_reg [16];
  initial begin
    for (int k = 0; k < 16; k++) begin
      mem_reg[k] = 8'(k);
    end
  end
  assign o_byte = mem_reg[i_idx];
  // takes the cleared bit or decremented byte
  always @(posedge i_clk) begin
    if (i_done && i_res.wr_en) begin
      mem_reg[i_idx] <= i_res.wr_data;
    end
  end
endmodule

// *** tb/bbc_exec_asserts.sv ***
// bbc_exec_asserts: timing and effect checks on the core ports
// assumes binding onto bbc_exec
`timescale 1ns/1ps
module bbc_exec_asserts #(
  parameter int P_EXT_WAIT = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // instruction port
  input wire logic i_req_valid,
  input wire bbc_pkg::bbc_req_t i_req,
  input wire logic o_req_ready,
  input wire logic o_done,
  input wire bbc_pkg::bbc_res_t o_res,
  // cpu state
  input wire logic [7:0] o_psw,
  input wire bbc_pkg::bbc_standby_t o_standby
);
  import bbc_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic take;
  bbc_op_t op;
  assign take = i_req_valid && o_req_ready && !i_req.ext_prog;
  assign op = i_req.op;
  chk_acc_eight:
    assert property (take && op == BBC_OP_BRANCH_IF_BIT_SET && i_req.mode == BBC_MODE_ACC
      |=> !o_done [*7] ##1 o_done) else $error("acc bit branch not 8 clocks");
  chk_sfr_eleven:
    assert property (take && op == BBC_OP_BRANCH_IF_BIT_CLEAR && i_req.mode == BBC_MODE_SFR
      |-> ##3 !o_done [*8] ##1 o_done) else $error("sfr bit branch not 11 clocks");
  chk_nop_only_pc:
    assert property (take && op == BBC_OP_NOP |-> ##2 o_done && $stable(o_psw)
      && o_res.next_pc == $past(i_req.pc, 2) + 16'h1) else $error("nop result wrong");
  chk_sel_bank:
    assert property (take && op == BBC_OP_SELECT_BANK |-> ##4 o_done
      && o_psw[5] == $past(i_req.bit_sel[1], 4) && o_psw[3] == $past(i_req.bit_sel[0], 4))
      else $error("bank bits wrong");
  chk_ie_flag:
    assert property (take && op inside {BBC_OP_ENABLE_INTERRUPT, BBC_OP_DISABLE_INTERRUPT}
      |-> ##6 o_done && o_psw[7] == ($past(op, 6) == BBC_OP_ENABLE_INTERRUPT))
      else $error("interrupt enable flag wrong");
  chk_standby_entry:
    assert property (take && op inside {BBC_OP_HALT, BBC_OP_STOP} |-> ##6 o_done
      && o_standby == ($past(op, 6) == BBC_OP_HALT ? BBC_HALT : BBC_STOP))
      else $error("standby entry wrong");
  chk_ready_standby:
    assert property (o_standby != BBC_RUN |-> !o_req_ready) else $error("ready in standby");
  chk_dec_loop:
    assert property (take && op == BBC_OP_DECREMENT_BRANCH_NONZERO && i_req.mode[2:1] == 2'b11
      |=> o_res.taken == ($past(i_req.operand) != 8'h01) && o_res.next_pc == $past(i_req.pc)
      + 16'h2 + (o_res.taken ? {{8{$past(i_req.disp[7])}}, $past(i_req.disp)} : 16'h0))
      else $error("decrement branch wrong");
  cov_taken: cover property (o_done && o_res.taken);
  cov_write: cover property (o_done && o_res.wr_en);
  cov_stop: cover property (o_standby == BBC_STOP);
endmodule
bind bbc_exec bbc_exec_asserts #(.P_EXT_WAIT(P_EXT_WAIT)) u_chk (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
  .o_done(o_done), .o_res(o_res), .o_psw(o_psw), .o_standby(o_standby));

// *** tb/bbc_exec_tb.sv ***
// bbc_exec_tb: self-checking bench for the execution core
// assumes package, memory model and checker compiled first
`timescale 1ns/1ps
module bbc_exec_tb;
  import bbc_pkg::*;
  localparam int P_WAIT = 3;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_req_valid = 1'b0;
  bbc_req_t i_req = '0;
  logic i_wake = 1'b0;
  logic [3:0] i_reg_addr = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic o_req_ready;
  logic o_done;
  bbc_res_t o_res;
  bbc_standby_t o_standby;
  logic [7:0] o_psw;
  logic [7:0] o_reg_rdata;
  logic [7:0] mem_byte;
  logic [3:0] idx = 4'h0;
  logic [7:0] sh [16];
  logic [7:0] exp_psw = 8'h02;
  int n_errors = 0;
  int checked = 0;
  always #5 i_clk = ~i_clk;
  bbc_exec #(.P_EXT_WAIT(P_WAIT)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done),
    .o_res(o_res), .o_psw(o_psw), .o_standby(o_standby), .i_wake(i_wake),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
  bbc_mem_model mem (.i_clk(i_clk), .i_idx(idx), .i_done(o_done), .i_res(o_res),
    .o_byte(mem_byte));
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    check(o_reg_rdata, want, "register read");
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic run(input bbc_op_t op, input bbc_mode_t md, input logic [2:0] b,
      input logic [7:0] d, input logic [3:0] k, input logic hs, input logic ext,
      input int cyc, input logic [2:0] len, input logic tk);
    int n;
    n = 0;
    @(posedge i_clk);
    idx <= k;
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req <= '{op: op, mode: md, bit_sel: b, disp: d, pc: 16'h0100, operand: mem_byte,
      hs_ram: hs, ext_prog: ext};
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    while (o_done !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 40) begin
      n_errors++;
      give_verdict();
    end
    check(16'(n), 16'(cyc), "clocks");
    check(o_res.taken, tk, "taken");
    check(o_res.next_pc, 16'h0100 + len + (tk ? {{8{d[7]}}, d} : 16'h0), "pc");
    check(o_psw, exp_psw, "psw");
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (o_standby !== BBC_RUN && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 20) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic t_regs();
    rd(4'h0, 8'h02);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    wr(4'h0, 8'h81);
    exp_psw = 8'h81;
    rd(4'h0, 8'h81);
    $display("register test done");
  endtask
  task automatic t_bits();
    logic [15:0] tbl [15] = '{16'h1893, 16'h2bb4, 16'h3883, 16'h4993, 16'h5ab3,
      16'h1ab4, 16'h2bb4, 16'h3883, 16'h4bb4, 16'h5ab3,
      16'h1ac4, 16'h2cc4, 16'h3883, 16'h4cc4, 16'h5ac3};
    logic [7:0] v;
    logic tk;
    bbc_op_t op;
    bbc_mode_t md;
    for (int e = 0; e < 15; e++) begin
      for (int k = 0; k < 4; k++) begin
        op = e < 5 ? BBC_OP_BRANCH_IF_BIT_SET : e < 10 ? BBC_OP_BRANCH_IF_BIT_CLEAR :
          BBC_OP_BRANCH_AND_CLEAR_BIT;
        md = bbc_mode_t'(tbl[e][14:12]);
        v = md == BBC_MODE_PSW ? exp_psw : sh[5];
        tk = op == BBC_OP_BRANCH_IF_BIT_CLEAR ? !v[k % 2] : v[k % 2];
        if (op == BBC_OP_BRANCH_AND_CLEAR_BIT && tk && md == BBC_MODE_PSW) begin
          exp_psw[k % 2] = 1'b0;
        end else if (op == BBC_OP_BRANCH_AND_CLEAR_BIT && tk) begin
          sh[5][k % 2] = 1'b0;
        end
        run(op, md, 3'(k % 2), k % 2 ? 8'h10 : 8'hfe, 4'h5, k < 2, 1'b0,
          k < 2 ? tbl[e][11:8] : tbl[e][7:4], tbl[e][2:0], tk);
        if (md != BBC_MODE_PSW) begin
          check(o_res.wr_en, op == BBC_OP_BRANCH_AND_CLEAR_BIT && tk, "wr_en");
          check(o_res.wr_data & {8{o_res.wr_en}}, sh[5] & {8{o_res.wr_en}}, "wr");
        end
      end
    end
    $display("bit branch test done");
  endtask
  task automatic t_decrement_branch_nonzero();
    logic [15:0] tbl [4] = '{16'h6062, 16'h7162, 16'h1283, 16'h11a3};
    logic [3:0] k;
    for (int e = 0; e < 4; e++) begin
      k = tbl[e][11:8];
      sh[k] = sh[k] - 8'h01;
      run(BBC_OP_DECREMENT_BRANCH_NONZERO, bbc_mode_t'(tbl[e][14:12]), 3'h0, 8'h85, k,
        e != 3, 1'b0, tbl[e][7:4], tbl[e][2:0], sh[k] != 8'h00);
      check(o_res.wr_data, sh[k], "decremented byte");
      check(o_res.wr_mode, tbl[e][14:12], "write target");
    end
    $display("decrement test done");
  endtask
  task automatic t_ctrl();
    run(BBC_OP_BRANCH_IF_BIT_SET, BBC_MODE_REG_B, 0, 8'h10, 0, 1, 0, 2, 1, 0);
    check(o_res.illegal, 1'b1, "illegal");
    check(o_res.wr_en, 1'b0, "no write");
    for (int n = 0; n < 4; n++) begin
      exp_psw[5] = n[1];
      exp_psw[3] = n[0];
      run(BBC_OP_SELECT_BANK, BBC_MODE_NONE, 3'(n), 8'h00, 4'h0, 1, 0, 4, 2, 0);
    end
    exp_psw[7] = 1'b1;
    run(BBC_OP_ENABLE_INTERRUPT, BBC_MODE_NONE, 0, 0, 0, 1, 0, 6, 2, 0);
    exp_psw[7] = 1'b0;
    run(BBC_OP_DISABLE_INTERRUPT, BBC_MODE_NONE, 0, 0, 0, 1, 0, 6, 2, 0);
    run(BBC_OP_NOP, BBC_MODE_NONE, 0, 0, 0, 1, 0, 2, 1, 0);
    run(BBC_OP_NOP, BBC_MODE_NONE, 0, 0, 0, 1, 1, 2 + P_WAIT, 1, 0);
    rd(4'h2, 8'(2 + P_WAIT));
    $display("control test done");
  endtask
  task automatic t_standby();
    run(BBC_OP_HALT, BBC_MODE_NONE, 0, 0, 0, 1, 0, 6, 2, 0);
    check(o_standby, BBC_HALT, "halt");
    rd(4'h1, 8'h01);
    @(posedge i_clk);
    i_wake <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_wake <= 1'b0;
    wait_run();
    run(BBC_OP_STOP, BBC_MODE_NONE, 0, 0, 0, 1, 0, 6, 2, 0);
    check(o_standby, BBC_STOP, "stop");
    wr(4'h1, 8'h01);
    wait_run();
    run(BBC_OP_NOP, BBC_MODE_NONE, 0, 0, 0, 1, 0, 2, 1, 0);
    $display("standby test done");
  endtask
  initial begin
    for (int k = 0; k < 16; k++) begin
      sh[k] = 8'(k);
    end
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_bits();
    t_decrement_branch_nonzero();
    t_ctrl();
    t_standby();
    give_verdict();
  end
endmodule
